// File: pkg/pbmc_pkg.sv
// Constants, field layout and carrier types of the basic mode control block.
// Assumes a single 10 MHz system clock; all timing counts derive from it.
package pbmc_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 100;

  // Register map
  localparam logic [4:0] BASIC_CONTROL_OFFSET = 5'h00;
  localparam logic [15:0] BASIC_CONTROL_RESET = 16'h3000;

  // Field positions
  localparam int BIT_SW_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPEED = 13;
  localparam int BIT_AN_ENABLE = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COL_TEST = 7;
  localparam logic [6:0] RESERVED_VALUE = 7'h00;

  // Software reset duration, least time rounded up
  localparam int SW_RESET_TIME_NS = 1000;
  localparam int SW_RESET_CYCLES = (SW_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Strap capture after reset release
  localparam logic [2:0] STRAP_SETTLE_COUNT = 3'h4;

  // Management frame layout
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] FRAME_HDR_LAST = 5'h0D;
  localparam logic [4:0] FRAME_TA_FIRST = 5'h0E;
  localparam logic [4:0] FRAME_LAST = 5'h1F;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // Collision test timing, longest times rounded down, at least one cycle
  localparam int BIT_TIME_100_NS = 10;
  localparam int COL_ON_BIT_TIMES = 512;
  localparam int COL_OFF_BIT_TIMES = 4;
  localparam int COL_ON_RAW = (COL_ON_BIT_TIMES * BIT_TIME_100_NS) / CLK_PERIOD_NS;
  localparam int COL_OFF_RAW = (COL_OFF_BIT_TIMES * BIT_TIME_100_NS) / CLK_PERIOD_NS;
  localparam int COL_ON_MAX_CYCLES = (COL_ON_RAW < 1) ? 1 : COL_ON_RAW;
  localparam int COL_OFF_MAX_CYCLES = (COL_OFF_RAW < 1) ? 1 : COL_OFF_RAW;
  localparam int COL_ON_DELAY = 2;

  // Carriers
  typedef struct packed {
    logic basic_mode;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
    logic isolate;
  } pbmc_strap_type;

  typedef struct packed {
    logic [3:0] data;
    logic valid;
  } pbmc_nibble_type;

  typedef enum logic [2:0] {
    SMI_PREAMBLE = 3'h1,
    SMI_HEADER = 3'h2,
    SMI_DATA = 3'h4
  } pbmc_smi_state_type;

endpackage : pbmc_pkg

// File: rtl/pbmc_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs asynchronous to clk_sys; output changes only once stages two and three agree.
`timescale 1ns/1ps
module pbmc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] next_sync = (stage2 & stage3) | (sync_out & (stage2 | stage3));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_sync;
    end
  end

endmodule : pbmc_sync

// File: rtl/pbmc_col_test.sv
// Collision test responder: COL follows TX_EN while the test is on.
// Assumes tx_en is on clk_sys; ON_DELAY must stay within the 512 bit-time bound.
`timescale 1ns/1ps
module pbmc_col_test #(
  parameter int ON_DELAY = pbmc_pkg::COL_ON_DELAY
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic test_enable,
  input wire logic tx_en,
  // Result
  output logic col
);

  logic [7:0] delay_cnt;
  wire active = test_enable && tx_en;
  wire delay_done = delay_cnt == 8'(ON_DELAY - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt <= 8'h00;
      col <= 1'h0;
    end else if (!active) begin
      // Drop at once: one cycle, the floor COL_OFF_MAX_CYCLES puts on the 4 bit-time bound
      delay_cnt <= 8'h00;
      col <= 1'h0;
    end else if (!col) begin
      if (delay_done) begin
        col <= 1'h1;
      end else begin
        delay_cnt <= delay_cnt + 8'h01;
      end
    end
  end

endmodule : pbmc_col_test

// File: rtl/pbmc_basic_control.sv
// Basic mode control register of a 10/100 PHY, reached over the management pins.
// Assumes a slow MDC (well under a quarter of clk_sys) and MII signals on clk_sys.
`timescale 1ns/1ps

// How it works
// - Writing one to bit 15 resets standard register
// - Reset bit clears itself when reset ends
// - Vendor extended registers survive software reset
// - Loopback routes transmit nibbles onto receive
// - Manual speed bit: zero 10, one 100
// - Basic pinout: speed strap when negotiation off
// - Negotiation enable always loaded from strap
// - Negotiation on ignores manual speed and duplex
// - Power down is bit OR low pin
// - Isolate disconnects MII, management still works
// - Isolate in RMII master stops reference clock
// - Basic pinout: isolate taken from strap
// - Restart write ignored while negotiation disabled
// - Restart reads one until negotiation restarts
// - Writing zero to restart changes nothing
// - Manual duplex bit: zero half, one full
// - Basic pinout: duplex taken from strap
// - Collision test raises COL after TX_EN
// - Collision test drops COL after TX_EN
module pbmc_basic_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Straps and control pins
  input wire logic [4:0] phy_addr,
  input wire pbmc_pkg::pbmc_strap_type strap_pins,
  input wire logic low_power_request_pin_n,
  input wire logic rmii_master,
  // Auto-negotiation engine
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic an_restart_ack,
  output logic an_enable,
  output logic an_restart,
  // MII
  input wire pbmc_pkg::pbmc_nibble_type mii_tx,
  input wire pbmc_pkg::pbmc_nibble_type core_rx,
  output pbmc_pkg::pbmc_nibble_type mii_rx,
  output logic mii_col,
  output logic mii_out_en,
  // Port control
  output logic speed_100,
  output logic full_duplex,
  output logic power_down,
  output logic pcs_reset,
  output logic ref_clk_en
);

  localparam int COL_ON_LIM = pbmc_pkg::COL_ON_MAX_CYCLES;

  // Reset release
  logic [1:0] rst_pipe;
  wire rst_n = rst_pipe[1];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end

  // Pin synchronisers
  logic [2:0] mgmt_s;
  logic [9:0] strap_bus_s;

  pbmc_sync #(.WIDTH(3), .INIT(3'h1)) u_mgmt_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({mdc, mdio_in, low_power_request_pin_n}),
    .sync_out(mgmt_s)
  );

  pbmc_sync #(.WIDTH(10), .INIT(10'h000)) u_strap_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({strap_pins, phy_addr}),
    .sync_out(strap_bus_s)
  );

  wire mdc_s = mgmt_s[2];
  wire mdio_s = mgmt_s[1];
  wire pwdn_req = !mgmt_s[0];
  wire pbmc_pkg::pbmc_strap_type strap_s = strap_bus_s[9:5];

  // Strap capture, once the synchroniser has filled
  logic [2:0] settle_cnt;
  logic strap_done;
  pbmc_pkg::pbmc_strap_type strap_q;
  logic [4:0] addr_q;
  wire strap_latch = !strap_done && settle_cnt == pbmc_pkg::STRAP_SETTLE_COUNT;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 3'h0;
      strap_done <= 1'h0;
      strap_q <= '0;
      addr_q <= 5'h00;
    end else if (strap_latch) begin
      strap_done <= 1'h1;
      strap_q <= strap_s;
      addr_q <= strap_bus_s[4:0];
    end else if (!strap_done) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end

  // Defaults from straps
  wire pbmc_pkg::pbmc_strap_type strap_src = strap_done ? strap_q : strap_s;
  wire strap_speed = strap_src.basic_mode && !strap_src.an_enable;
  wire def_speed = strap_speed ? strap_src.speed_100 :
    pbmc_pkg::BASIC_CONTROL_RESET[pbmc_pkg::BIT_SPEED];
  wire def_iso = strap_src.basic_mode ? strap_src.isolate :
    pbmc_pkg::BASIC_CONTROL_RESET[pbmc_pkg::BIT_ISOLATE];
  wire def_duplex = strap_src.basic_mode ? strap_src.full_duplex :
    pbmc_pkg::BASIC_CONTROL_RESET[pbmc_pkg::BIT_DUPLEX];

  // Management frame receiver
  pbmc_pkg::pbmc_smi_state_type smi_state;
  pbmc_pkg::pbmc_smi_state_type next_state;
  logic [5:0] pre_cnt;
  logic [5:0] next_pre;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit;
  logic [12:0] hdr;
  logic mdc_d;
  wire mdc_rise = mdc_s && !mdc_d;
  wire [13:0] hdr_next = {hdr, mdio_s};

  always_comb begin
    next_state = smi_state;
    next_pre = pre_cnt;
    next_bit = bit_cnt + 5'h01;
    case (smi_state)
      pbmc_pkg::SMI_PREAMBLE: begin
        next_bit = 5'h01;
        if (mdio_s) begin
          next_pre = (pre_cnt == pbmc_pkg::PREAMBLE_BITS) ? pre_cnt : pre_cnt + 6'h01;
        end else if (pre_cnt == pbmc_pkg::PREAMBLE_BITS) begin
          next_state = pbmc_pkg::SMI_HEADER;
        end else begin
          next_pre = 6'h00;
        end
      end
      pbmc_pkg::SMI_HEADER: begin
        if (bit_cnt == pbmc_pkg::FRAME_HDR_LAST) begin
          next_state = pbmc_pkg::SMI_DATA;
        end
      end
      pbmc_pkg::SMI_DATA: begin
        if (bit_cnt == pbmc_pkg::FRAME_LAST) begin
          next_state = pbmc_pkg::SMI_PREAMBLE;
          next_pre = 6'h00;
        end
      end
      default: begin
        next_state = pbmc_pkg::SMI_PREAMBLE;
        next_pre = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdc_d <= 1'h0;
    end else begin
      mdc_d <= mdc_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      smi_state <= pbmc_pkg::SMI_PREAMBLE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      hdr <= 13'h0000;
    end else if (mdc_rise) begin
      smi_state <= next_state;
      pre_cnt <= next_pre;
      bit_cnt <= next_bit;
      hdr <= hdr_next[12:0];
    end
  end

  // Frame decode at the last header bit
  logic rd_ok;
  logic wr_ok;
  logic reg_hit;
  logic [15:0] rd_sh;
  logic [14:0] wr_sh;
  logic [15:0] ctl_word;
  wire in_data = smi_state == pbmc_pkg::SMI_DATA;
  wire hdr_end = mdc_rise && smi_state == pbmc_pkg::SMI_HEADER &&
    bit_cnt == pbmc_pkg::FRAME_HDR_LAST;
  wire hdr_ok = strap_done && hdr_next[13:12] == pbmc_pkg::FRAME_START &&
    hdr_next[9:5] == addr_q;
  wire reg_sel = hdr_next[4:0] == pbmc_pkg::BASIC_CONTROL_OFFSET;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_ok <= 1'h0;
      wr_ok <= 1'h0;
      reg_hit <= 1'h0;
    end else if (hdr_end) begin
      rd_ok <= hdr_ok && hdr_next[11:10] == pbmc_pkg::OP_READ;
      wr_ok <= hdr_ok && hdr_next[11:10] == pbmc_pkg::OP_WRITE;
      reg_hit <= reg_sel;
    end
  end

  // Read answer: driven after each MDC rise, host samples on the next
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_sh <= 16'h0000;
      mdio_oe <= 1'h0;
      mdio_out <= 1'h0;
    end else if (hdr_end) begin
      rd_sh <= reg_sel ? ctl_word : 16'h0000;
    end else if (mdc_rise && in_data && rd_ok) begin
      if (bit_cnt == pbmc_pkg::FRAME_TA_FIRST) begin
        mdio_oe <= 1'h1;
        mdio_out <= 1'h0;
      end else if (bit_cnt == pbmc_pkg::FRAME_LAST) begin
        mdio_oe <= 1'h0;
        mdio_out <= 1'h0;
      end else begin
        mdio_out <= rd_sh[15];
        rd_sh <= {rd_sh[14:0], 1'h0};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_sh <= 15'h0000;
    end else if (mdc_rise && in_data) begin
      wr_sh <= {wr_sh[13:0], mdio_s};
    end
  end

  // Register write and software reset
  logic sw_rst;
  logic [7:0] swrst_cnt;
  logic ctl_loop;
  logic ctl_speed;
  logic ctl_an_en;
  logic ctl_pd;
  logic ctl_iso;
  logic ctl_restart;
  logic ctl_duplex;
  logic ctl_col_test;
  wire [15:0] wdata = {wr_sh, mdio_s};
  wire wr_strobe = mdc_rise && in_data && bit_cnt == pbmc_pkg::FRAME_LAST &&
    wr_ok && reg_hit;
  // Writes landing mid-reset are dropped; the reset owns the register then
  wire wr_take = wr_strobe && !sw_rst;
  wire sw_done = sw_rst && swrst_cnt == 8'h01;
  wire load_defaults = strap_latch || sw_done;
  wire restart_set = wr_take && wdata[pbmc_pkg::BIT_AN_RESTART] &&
    wdata[pbmc_pkg::BIT_AN_ENABLE];
  wire next_restart = restart_set || (ctl_restart && !an_restart_ack);
  wire next_pd = pwdn_req || (wr_take ? wdata[pbmc_pkg::BIT_POWER_DOWN] : ctl_pd);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sw_rst <= 1'h0;
      swrst_cnt <= 8'h00;
    end else if (wr_take && wdata[pbmc_pkg::BIT_SW_RESET]) begin
      sw_rst <= 1'h1;
      swrst_cnt <= 8'(pbmc_pkg::SW_RESET_CYCLES);
    end else if (sw_rst) begin
      swrst_cnt <= swrst_cnt - 8'h01;
      sw_rst <= !sw_done;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_restart <= 1'h0;
      ctl_pd <= 1'h0;
    end else begin
      ctl_restart <= !load_defaults && next_restart;
      ctl_pd <= load_defaults ? pwdn_req : next_pd;
    end
  end

  // Only this register is held here, so vendor registers are untouched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_loop <= 1'h0;
      ctl_speed <= pbmc_pkg::BASIC_CONTROL_RESET[pbmc_pkg::BIT_SPEED];
      ctl_an_en <= pbmc_pkg::BASIC_CONTROL_RESET[pbmc_pkg::BIT_AN_ENABLE];
      ctl_iso <= 1'h0;
      ctl_duplex <= 1'h0;
      ctl_col_test <= 1'h0;
    end else if (load_defaults) begin
      ctl_loop <= 1'h0;
      ctl_speed <= def_speed;
      ctl_an_en <= strap_src.an_enable;
      ctl_iso <= def_iso;
      ctl_duplex <= def_duplex;
      ctl_col_test <= 1'h0;
    end else if (wr_take) begin
      ctl_loop <= wdata[pbmc_pkg::BIT_LOOPBACK];
      ctl_speed <= wdata[pbmc_pkg::BIT_SPEED];
      ctl_an_en <= wdata[pbmc_pkg::BIT_AN_ENABLE];
      ctl_iso <= wdata[pbmc_pkg::BIT_ISOLATE];
      ctl_duplex <= wdata[pbmc_pkg::BIT_DUPLEX];
      ctl_col_test <= wdata[pbmc_pkg::BIT_COL_TEST];
    end
  end

  assign ctl_word = {sw_rst, ctl_loop, ctl_speed, ctl_an_en, ctl_pd, ctl_iso,
    ctl_restart, ctl_duplex, ctl_col_test, pbmc_pkg::RESERVED_VALUE};

  // Port control and MII datapath
  wire pd_now = ctl_pd || pwdn_req;
  wire pbmc_pkg::pbmc_nibble_type rx_src = ctl_loop ? mii_tx : core_rx;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      speed_100 <= 1'h0;
      full_duplex <= 1'h0;
      power_down <= 1'h0;
      ref_clk_en <= 1'h0;
      mii_out_en <= 1'h0;
      mii_rx <= '0;
    end else begin
      speed_100 <= ctl_an_en ? an_speed_100 : ctl_speed;
      full_duplex <= ctl_an_en ? an_full_duplex : ctl_duplex;
      power_down <= pd_now;
      ref_clk_en <= !(ctl_iso && rmii_master);
      mii_out_en <= !ctl_iso;
      mii_rx <= pd_now ? '0 : rx_src;
    end
  end

  assign an_enable = ctl_an_en;
  assign an_restart = ctl_restart;
  assign pcs_reset = sw_rst;

  pbmc_col_test #(.ON_DELAY(pbmc_pkg::COL_ON_DELAY)) u_col_test (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .test_enable(ctl_col_test && !power_down),
    .tx_en(mii_tx.valid),
    .col(mii_col)
  );

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_swrst_hold;
    sw_rst [*8];
  endsequence

  sequence s_tx_held;
    (ctl_col_test && !power_down && mii_tx.valid) [*3];
  endsequence

  chk_swrst_self_clear: assert property (
    $rose(sw_rst) |-> s_swrst_hold ##3 !sw_rst)
    else $error("software reset did not clear after its duration");

  chk_swrst_defaults: assert property (
    $fell(sw_rst) |-> !ctl_loop && !ctl_col_test && !ctl_restart)
    else $error("software reset left control bits set");

  chk_loop_route: assert property (
    (ctl_loop && !pd_now) |=> mii_rx == $past(mii_tx))
    else $error("loopback did not return transmit data");

  chk_an_overrides: assert property (
    ctl_an_en |=> speed_100 == $past(an_speed_100) && full_duplex == $past(an_full_duplex))
    else $error("negotiated speed or duplex not used");

  chk_manual_mode: assert property (
    !ctl_an_en |=> speed_100 == $past(ctl_speed) && full_duplex == $past(ctl_duplex))
    else $error("manual speed or duplex not applied");

  chk_pin_power_down: assert property (
    pwdn_req |=> ctl_pd && power_down)
    else $error("power-down pin did not set power down");

  chk_pd_gates_rx: assert property (
    power_down |-> mii_rx == '0)
    else $error("receive path active in power down");

  chk_restart_ignored: assert property (
    (wr_strobe && !wdata[pbmc_pkg::BIT_AN_ENABLE] && !ctl_restart) |=> !ctl_restart)
    else $error("restart accepted with negotiation disabled");

  chk_restart_hold: assert property (
    (ctl_restart && !an_restart_ack && !load_defaults) |=> ctl_restart)
    else $error("restart bit cleared before negotiation restarted");

  chk_isolate_pins: assert property (
    (ctl_iso && rmii_master) |=> !ref_clk_en && !mii_out_en)
    else $error("isolate did not stop clock and MII drive");

  chk_col_raise: assert property (
    s_tx_held |-> ##[0:COL_ON_LIM] (mii_col || !mii_tx.valid))
    else $error("collision test did not raise COL");

  chk_col_drop: assert property (
    $fell(mii_tx.valid) |=> !mii_col)
    else $error("COL not dropped after transmit end");

  // Watches the wire itself: bits 6 to 0 leave after rises 24 to 30
  chk_reserved_zero: assert property (
    (mdc_rise && in_data && rd_ok && bit_cnt >= 5'h18 && bit_cnt < pbmc_pkg::FRAME_LAST)
      |=> !mdio_out)
    else $error("reserved bits did not read zero");

endmodule : pbmc_basic_control

// File: sim/pbmc_smi_host.sv
// Station management host model: builds clause-22 frames on MDC/MDIO.
// Assumes the bench resolves MDIO with a pull-up and feeds it back as mdio_wire.
`timescale 1ns/1ps
module pbmc_smi_host (
  // Clock
  input wire logic clk_sys,
  // Management pins
  input wire logic mdio_wire,
  output logic mdc,
  output logic host_do,
  output logic host_oe,
  // Read result
  output logic [15:0] rd_data,
  output logic rd_valid
);
  initial begin
    mdc = 1'b0;
    host_do = 1'b1;
    host_oe = 1'b0;
    rd_data = 16'h0000;
    rd_valid = 1'b0;
  end

  // Half period of 8 cycles, well above the six the sampler needs
  task automatic one_bit(input logic b, input logic drv, output logic s);
    mdc <= 1'b0;
    host_do <= b;
    host_oe <= drv;
    repeat (8) @(posedge clk_sys);
    mdc <= 1'b1;
    s = mdio_wire;
    repeat (8) @(posedge clk_sys);
  endtask : one_bit

  // Full preamble every frame; line released through turnaround of a read
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd);
    logic [63:0] f;
    logic s;
    f = {32'hFFFFFFFF, pbmc_pkg::FRAME_START, rd ? pbmc_pkg::OP_READ : pbmc_pkg::OP_WRITE,
        pa, ra, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      one_bit(f[i], !(rd && i < 18), s);
      if (i < 16) rd_data[i] <= s;
    end
    mdc <= 1'b0;
    host_oe <= 1'b0;
    rd_valid <= rd;
    @(posedge clk_sys);
    rd_valid <= 1'b0;
  endtask : xfer
endmodule : pbmc_smi_host

// File: sim/pbmc_basic_control_tb_top.sv
// Self-checking bench for the basic mode control register block.
// Assumes the host model in pbmc_smi_host; MDIO is pulled up when idle.
`timescale 1ns/1ps
module pbmc_basic_control_tb_top;
  localparam logic [4:0] ADDR = 5'h05;
  localparam pbmc_pkg::pbmc_strap_type STRAP = 5'h1E;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic low_power_request_pin_n = 1'b1;
  logic rmii_master = 1'b0;
  logic an_speed_100 = 1'b0;
  logic an_full_duplex = 1'b0;
  logic an_restart_ack = 1'b0;
  pbmc_pkg::pbmc_nibble_type mii_tx = 5'h00;
  pbmc_pkg::pbmc_nibble_type core_rx = 5'h00;
  pbmc_pkg::pbmc_nibble_type mii_rx;
  logic mdc, host_do, host_oe, mdio_out, mdio_oe, rd_valid, an_enable, an_restart;
  logic mii_col, mii_out_en, speed_100, full_duplex, power_down, pcs_reset, ref_clk_en;
  logic [15:0] rd_data;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h5708AD5F;
  int err_total = 0;
  int checked = 0;
  int run_len = 0;
  int last_len = 0;
  wire logic mdio_wire = mdio_oe ? mdio_out : (host_oe ? host_do : 1'b1);

  pbmc_basic_control u_pbmc_basic_control (.clk_sys(clk_sys), .rstn(rstn), .mdc(mdc),
    .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(ADDR),
    .strap_pins(STRAP), .low_power_request_pin_n(low_power_request_pin_n),
    .rmii_master(rmii_master), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
    .an_restart_ack(an_restart_ack), .an_enable(an_enable), .an_restart(an_restart),
    .mii_tx(mii_tx), .core_rx(core_rx), .mii_rx(mii_rx), .mii_col(mii_col),
    .mii_out_en(mii_out_en), .speed_100(speed_100), .full_duplex(full_duplex),
    .power_down(power_down), .pcs_reset(pcs_reset), .ref_clk_en(ref_clk_en));

  pbmc_smi_host u_pbmc_smi_host (.clk_sys(clk_sys), .mdio_wire(mdio_wire), .mdc(mdc),
    .host_do(host_do), .host_oe(host_oe), .rd_data(rd_data), .rd_valid(rd_valid));

  always #(pbmc_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic final_report;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic check_port(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_port

  task automatic check_reg(input logic [15:0] got);
    logic [15:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hXXXX;
    check_port(got, e);
  endtask : check_reg

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    @(posedge clk_sys);
    u_pbmc_smi_host.xfer(1'b0, ADDR, ra, d);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : wr

  // Expected value is queued before the frame goes out
  task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    u_pbmc_smi_host.xfer(1'b1, pa, ra, 16'h0000);
  endtask : rd

  // Bounded wait; a spent bound ends the run
  task automatic wait_bit(ref logic s, input logic want, input int lim);
    int n;
    n = 0;
    while (s !== want && n <= lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check_port(16'(s), 16'(want));
    if (n > lim) final_report();
  endtask : wait_bit

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) check_reg(rd_data);
  end

  // Length of each software reset pulse
  always @(posedge clk_sys) begin
    if (pcs_reset === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rd(ADDR, 5'h00, 16'h3100);
    rd(ADDR + 5'h01, 5'h00, 16'hFFFF);
    check_port(16'(an_enable), 16'h0001);
    wr(5'h00, 16'h127F);
    check_port(16'(an_restart), 16'h0001);
    rd(ADDR, 5'h00, 16'h1200);
    wr(5'h00, 16'h1000);
    rd(ADDR, 5'h00, 16'h1200);
    @(posedge clk_sys);
    an_restart_ack <= 1'b1;
    @(posedge clk_sys);
    an_restart_ack <= 1'b0;
    wait_bit(an_restart, 1'b0, 4);
    rd(ADDR, 5'h00, 16'h1000);
    wr(5'h00, 16'h0200);
    check_port(16'(an_restart), 16'h0000);
    rd(ADDR, 5'h00, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(5'h00, {2'h0, i[1], 4'h0, i[0], 8'h00});
      check_port(16'(speed_100), 16'(i[1]));
      check_port(16'(full_duplex), 16'(i[0]));
    end
    @(posedge clk_sys);
    seed = lfsr(seed);
    an_speed_100 <= seed[0];
    an_full_duplex <= seed[1];
    wr(5'h00, 16'h1000);
    check_port({14'h0000, speed_100, full_duplex}, {14'h0000, seed[0], seed[1]});
    @(posedge clk_sys);
    an_speed_100 <= ~seed[0];
    an_full_duplex <= ~seed[1];
    repeat (2) @(posedge clk_sys);
    #1;
    check_port({14'h0000, speed_100, full_duplex}, {14'h0000, ~seed[0], ~seed[1]});
    wr(5'h16, 16'h0004);
    rd(ADDR, 5'h16, 16'h0000);
    for (int lb = 1; lb >= 0; lb--) begin
      wr(5'h00, lb ? 16'h6100 : 16'h2100);
      repeat (4) begin
        @(posedge clk_sys);
        seed = lfsr(seed);
        mii_tx <= seed[4:0];
        core_rx <= seed[9:5];
        @(posedge clk_sys);
        #1;
        check_port({11'h000, mii_rx}, {11'h000, lb ? mii_tx : core_rx});
      end
    end
    @(posedge clk_sys);
    mii_tx <= 5'h00;
    wr(5'h00, 16'h0080);
    @(posedge clk_sys);
    mii_tx <= 5'h01;
    wait_bit(mii_col, 1'b1, pbmc_pkg::COL_ON_MAX_CYCLES + 1);
    @(posedge clk_sys);
    mii_tx <= 5'h00;
    wait_bit(mii_col, 1'b0, pbmc_pkg::COL_OFF_MAX_CYCLES + 1);
    @(posedge clk_sys);
    low_power_request_pin_n <= 1'b0;
    core_rx <= 5'h1F;
    wait_bit(power_down, 1'b1, 10);
    repeat (2) @(posedge clk_sys);
    #1;
    check_port({11'h000, mii_rx}, 16'h0000);
    rd(ADDR, 5'h00, 16'h0880);
    @(posedge clk_sys);
    low_power_request_pin_n <= 1'b1;
    wr(5'h00, 16'h0000);
    wait_bit(power_down, 1'b0, 10);
    @(posedge clk_sys);
    rmii_master <= 1'b1;
    wr(5'h00, 16'h0400);
    check_port({14'h0000, mii_out_en, ref_clk_en}, 16'h0000);
    rd(ADDR, 5'h00, 16'h0400);
    @(posedge clk_sys);
    rmii_master <= 1'b0;
    wait_bit(ref_clk_en, 1'b1, 4);
    wr(5'h00, 16'h0000);
    check_port(16'(mii_out_en), 16'h0001);
    wr(5'h00, 16'h8000);
    rd(ADDR, 5'h00, 16'h3100);
    check_port(16'(last_len), 16'(pbmc_pkg::SW_RESET_CYCLES));
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule : pbmc_basic_control_tb_top
